// ==== bench/ipc_mic_pair.sv ====
// Purpose: Stereo PDM microphone pair as seen from its clock pin
// Assumes: The clock pin is sampled on mclk, as the mics slice bits on its edges
// Notes:   Reports the last half period and a running edge count
`timescale 1ns/100ps
module ipc_mic_pair (
  input  wire logic        mclk,
  input  wire logic        pdmClk,
  output logic      [15:0] halfLen,
  output logic      [15:0] edgeCnt
);
  logic        last_reg  = 1'h0;   // Previous pin level
  logic [15:0] run_reg   = 16'h0;  // Cycles since the last edge
  logic [15:0] half_reg  = 16'h0;  // Length of the last half period
  logic [15:0] edges_reg = 16'h0;  // Edges seen so far
  // Measure the clock the device generates toward the mics
  always @(posedge mclk) begin
    last_reg <= pdmClk;
    if (pdmClk !== last_reg) begin
      half_reg  <= run_reg + 16'h1;
      edges_reg <= edges_reg + 16'h1;
      run_reg   <= 16'h0;
    end else begin
      run_reg <= run_reg + 16'h1;
    end
  end
  assign halfLen = half_reg;
  assign edgeCnt = edges_reg;
endmodule : ipc_mic_pair

// ==== bench/test_input_path_config.sv ====
// Purpose: Self-checking bench of the input path configuration block
// Assumes: Reference clock of 400 ns, eight mclk cycles per reference period
// Notes:   Register rows first, then power modes, trigger and PDM clock cases
`timescale 1ns/100ps
module test_input_path_config;
  typedef struct packed {
    logic        doWr;   // Write before the read back
    logic [19:0] addr;   // Register address
    logic [31:0] wdata;  // Written value
    logic [31:0] exp;    // Expected read back
  } ipc_row_type;
  logic                         mclk, rst_n, wrStb, rdStb, pdmRefClk;
  logic [19:0]                  addr;
  logic [31:0]                  wdata, rdata, got;
  logic [1:0]                   pdm_clock_out, sharedMaxRate;
  ipc_pkg::ipc_chan_type [3:0]  chanCtl;
  logic [2:0]                   highpass_cutoff_select;
  logic                         rateMode;
  logic [1:0][1:0]              pathMaxRate;
  logic [15:0]                  halfLen, edgeCnt, edgeHold, halfLenP2;
  int                           failures, n_compared;
  ipc_row_type                  rows [0:15];
  ipc_input_path_config i_ipc_input_path_config (.mclk(mclk), .rst_n(rst_n), .wrStb(wrStb),
    .rdStb(rdStb), .addr(addr), .wdata(wdata), .rdata(rdata), .pdmRefClk(pdmRefClk),
    .pdm_clock_out(pdm_clock_out), .chanCtl(chanCtl),
    .highpass_cutoff_select(highpass_cutoff_select), .rateMode(rateMode),
    .pathMaxRate(pathMaxRate), .sharedMaxRate(sharedMaxRate));
  ipc_mic_pair i_ipc_mic_pair (.mclk(mclk), .pdmClk(pdm_clock_out[0]), .halfLen(halfLen),
    .edgeCnt(edgeCnt));
  ipc_mic_pair i_ipc_mic_pair_p2 (.mclk(mclk), .pdmClk(pdm_clock_out[1]), .halfLen(halfLenP2),
    .edgeCnt());
  // System clock, 50 ns
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Reference clock, unrelated phase
  initial begin
    pdmRefClk = 1'b0;
    #13;
    forever #200 pdmRefClk = ~pdmRefClk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // One write, strobe held for one edge
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge mclk); #2;
    wrStb = 1'b1; addr = a; wdata = d;
    @(posedge mclk); #2;
    wrStb = 1'b0;
  endtask : wr
  // One read, data taken once settled
  task automatic rd(input logic [19:0] a, output logic [31:0] d);
    @(posedge mclk); #2;
    rdStb = 1'b1; addr = a;
    @(posedge mclk); #2;
    rdStb = 1'b0;
    @(posedge mclk); #2;
    d = rdata;
  endtask : rd
  // Wait whole cycles
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : idle
  // Verdict and end of run
  task automatic wrap_up;
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  // Watchdog against a hang
  initial begin
    #(20000 * 50);
    failures++;
    wrap_up();
  end
  // Main sequence
  initial begin
    failures = 0; n_compared = 0;
    rst_n = 1'b0; wrStb = 1'b0; rdStb = 1'b0; addr = 20'h0; wdata = 32'h0;
    rows = '{'{1'b0, 20'h04008, 32'h0, 32'h00000400}, '{1'b0, 20'h04020, 32'h0, 32'h00050000},
      '{1'b0, 20'h04028, 32'h0, 32'h00000080}, '{1'b0, 20'h04244, 32'h0, 32'h00000002},
      '{1'b0, 20'h04024, 32'h0, 32'h00000000}, '{1'b0, 20'h19000, 32'h0, 32'h00000000},
      '{1'b1, 20'h04024, 32'h20000004, 32'h20000004},
      '{1'b1, 20'h04044, 32'h20000004, 32'h00000004},
      '{1'b1, 20'h04064, 32'h30000001, 32'h00000001},
      '{1'b1, 20'h04028, 32'h0000007e, 32'h00000080},
      '{1'b1, 20'h04028, 32'h000000ba, 32'h000000ba},
      '{1'b1, 20'h04048, 32'h000000bc, 32'h00000080},
      '{1'b1, 20'h04244, 32'h00000005, 32'h00000002},
      '{1'b1, 20'h04244, 32'h00000004, 32'h00000004},
      '{1'b1, 20'h04008, 32'h00000000, 32'h00000000},
      '{1'b1, 20'h04000, 32'h000000ff, 32'h00000000}};
    repeat (5) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    idle(2);
    check(rateMode, 32'h1);
    check(chanCtl[0].powerMode, ipc_pkg::PWR_HIGH_PERF);
    check(chanCtl[3].effectiveGain, 32'h40);
    // Register rows: reset values, reserved codes, unmapped place
    foreach (rows[i]) begin
      if (rows[i].doWr) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, got);
      check(got, rows[i].exp);
    end
    idle(3);
    check(rateMode, 32'h0);
    check(highpass_cutoff_select, 32'h4);
    check(chanCtl[0].sourceSel, ipc_pkg::SRC_DIFF_ALT);
    check(chanCtl[1].highpassEnable, 32'h1);
    check(chanCtl[0].effectiveGain, ipc_pkg::GAIN_MAX);
    check(chanCtl[2].powerMode, ipc_pkg::PWR_LOW_POWER);
    // Trigger edges with path 2 digital, bit 5 kept set
    wr(20'h04060, 32'h00050021);
    wr(20'h19000, 32'h00000001);
    idle(3);
    check(chanCtl[1].powerMode, ipc_pkg::PWR_STANDARD);
    check(chanCtl[2].powerMode, ipc_pkg::PWR_PDM);
    check(chanCtl[2].digital, 32'h1);
    wr(20'h19000, 32'h00000000);
    idle(3);
    check(chanCtl[0].powerMode, ipc_pkg::PWR_HIGH_PERF);
    // Mid power with a 1 dB gain lifted to 6 dB; path 1 analog, path 2 still PDM
    wr(20'h04020, 32'h00020020);
    wr(20'h04048, 32'h00000082);
    idle(3);
    check(chanCtl[1].powerMode, ipc_pkg::PWR_MID_POWER);
    check(chanCtl[1].effectiveGain, ipc_pkg::GAIN_MID_MIN);
    check(chanCtl[0].effectiveGain, ipc_pkg::GAIN_MAX);
    wr(20'h04020, 32'h00050020);
    idle(3);
    check(chanCtl[1].effectiveGain, 32'h41);
    // Slowest PDM clock: 32 reference edges of 8 cycles per half
    wr(20'h04020, 32'h00000021);
    idle(1200);
    check(halfLen, 32'h100);
    check(pathMaxRate[0], ipc_pkg::RATE_MAX_48K);
    check(sharedMaxRate, ipc_pkg::RATE_MAX_48K);
    // Second slowest clock: 16 reference edges per half, 96 kHz limit
    wr(20'h04020, 32'h00010021);
    idle(700);
    check(halfLen, 32'h80);
    check(pathMaxRate[0], ipc_pkg::RATE_MAX_96K);
    check(sharedMaxRate, ipc_pkg::RATE_MAX_96K);
    // Fastest PDM clock and its high-performance mode
    wr(20'h04020, 32'h00060021);
    idle(200);
    check(halfLen, 32'h10);
    check(chanCtl[0].powerMode, ipc_pkg::PWR_PDM_HIGH_PERF);
    check(sharedMaxRate, ipc_pkg::RATE_MAX_192K);
    // Reserved code stops the clock low
    wr(20'h04020, 32'h00070021);
    idle(100);
    edgeHold = edgeCnt;
    idle(200);
    check(edgeCnt, edgeHold);
    check(pdm_clock_out[0], 32'h0);
    check(halfLenP2, 32'h20);
    check(pathMaxRate[1], ipc_pkg::RATE_MAX_192K);
    // Reset in mid-run returns every control to its reset image
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(2);
    check(rateMode, 32'h1);
    check(chanCtl[1].powerMode, ipc_pkg::PWR_HIGH_PERF);
    check(chanCtl[2].digital, 32'h0);
    check(highpass_cutoff_select, ipc_pkg::HPF_CUT_RESET);
    check(pdm_clock_out, 32'h0);
    rd(20'h04020, got);
    check(got, 32'h00050000);
    wrap_up();
  end
endmodule : test_input_path_config

// ==== rtl/ipc_input_path_config.sv ====
// Purpose: Register control of two stereo input paths, power modes and PDM clocks
// Assumes: Single-cycle write and read strobes on mclk, reference clock on a pin
// Notes:   Channel outputs and read data come from flip-flops
// Function
// - Rate-mode bit: global or per-channel, reset one
// - Path bit 0 selects analog or PDM
// - Source field: differential, single, alternate pair (alternate on channel 0 only)
// - Per-channel highpass enable, one shared cut-off
// - Gain 0x40 is 0 dB, 1 dB steps
// - Analog oversample 010 mid, 101 normal
// - Digital oversample code sets PDM clock rate
// - Code 110 gives 6.144 MHz high-performance PDM
// - Slow PDM clocks limit allowed sample rate
// - Trigger edges switch analog paths standard/high
// - Digital paths ignore standard-mode changes
// - Analog paths start in high-performance mode
// - Mid-power lifts any gain below 6 dB to 6
// - Trigger is bit 0 at 0x19000
// - Cut-off codes 000 to 100, reset 010
`timescale 1ns/100ps
module ipc_input_path_config (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      wrStb,
  input  wire logic                      rdStb,
  input  wire logic [19:0]               addr,
  input  wire logic [31:0]               wdata,
  output logic      [31:0]               rdata,
  input  wire logic                      pdmRefClk,
  output logic      [1:0]                pdm_clock_out,
  output ipc_pkg::ipc_chan_type [3:0]    chanCtl,
  output logic      [2:0]                highpass_cutoff_select,
  output logic                           rateMode,
  output logic      [1:0][1:0]           pathMaxRate,
  output logic      [1:0]                sharedMaxRate
);

  // All state of the block
  typedef struct packed {
    logic                            rateMode;    // Rate selection mode
    logic [1:0][2:0]                 osr;         // Oversample code per path
    logic [1:0]                      keepBit;     // Bit 5 of each path word
    logic [1:0]                      digital;     // PDM select per path
    logic [3:0][1:0]                 src;         // Analog source per channel
    logic [3:0]                      hpf;         // Highpass enable per channel
    logic [3:0]                      lowPower;    // Low-power select per channel
    logic [3:0][6:0]                 gain;        // Preamp gain code per channel
    logic [2:0]                      hpfCut;      // Shared cut-off
    logic                            trig;        // Standard-mode trigger level
    logic [1:0]                      stdMode;     // Standard mode per path
    logic [31:0]                     rdata;       // Read data
    logic [2:0]                      refSync;     // Reference clock synchroniser
    ipc_pkg::ipc_chan_type [3:0]     chanOut;     // Registered channel controls
    logic [1:0][1:0]                 maxRate;     // Limit per path
    logic [1:0]                      sharedRate;  // Limit under global rate
  } ipc_state_type;

  ipc_state_type stReg;   // Registered state
  ipc_state_type stNext;  // Next state
  logic          refTick; // One pulse per rising reference edge

  // Edge of the reference clock, read only past the first flip-flop
  assign refTick = stReg.refSync[1] & ~stReg.refSync[2];

  // Reset image of the state
  function automatic ipc_state_type resetState();
    ipc_state_type s;
    s          = '0;
    s.rateMode = ipc_pkg::RATE_MODE_RESET;
    s.osr      = {2{ipc_pkg::OSR_RESET}};
    s.gain     = {4{ipc_pkg::GAIN_RESET}};
    s.hpfCut   = ipc_pkg::HPF_CUT_RESET;
    s.stdMode  = 2'h0;
    for (int c = 0; c < 4; c++) begin
      s.chanOut[c].powerMode     = ipc_pkg::PWR_HIGH_PERF;
      s.chanOut[c].effectiveGain = ipc_pkg::GAIN_RESET;
    end
    s.maxRate    = {2{ipc_pkg::RATE_MAX_192K}};
    s.sharedRate = ipc_pkg::RATE_MAX_192K;
    return s;
  endfunction : resetState

  // Limit on sample rate from a path's PDM clock
  function automatic logic [1:0] rateLimit(input logic dig, input logic [2:0] code);
    logic [1:0] r;
    r = ipc_pkg::RATE_MAX_192K;
    if (dig && code == 3'h0) begin
      r = ipc_pkg::RATE_MAX_48K;
    end else if (dig && code == 3'h1) begin
      r = ipc_pkg::RATE_MAX_96K;
    end
    return r;
  endfunction : rateLimit

  // Address of a channel's source and gain registers
  function automatic logic [19:0] srcAddr(input int c);
    logic [19:0] a;
    unique case (c)
      0:       a = ipc_pkg::ADDR_P1L_SRC;
      1:       a = ipc_pkg::ADDR_P1R_SRC;
      2:       a = ipc_pkg::ADDR_P2L_SRC;
      default: a = ipc_pkg::ADDR_P2R_SRC;
    endcase
    return a;
  endfunction : srcAddr

  function automatic logic [19:0] gainAddr(input int c);
    logic [19:0] a;
    unique case (c)
      0:       a = ipc_pkg::ADDR_P1L_GAIN;
      1:       a = ipc_pkg::ADDR_P1R_GAIN;
      2:       a = ipc_pkg::ADDR_P2L_GAIN;
      default: a = ipc_pkg::ADDR_P2R_GAIN;
    endcase
    return a;
  endfunction : gainAddr

  // Next-state logic: register writes, trigger edges, decode, read mux
  always_comb begin
    logic       newTrig;
    logic [1:0] code;
    logic [6:0] g;
    newTrig = stReg.trig;
    code    = 2'h0;
    g       = 7'h00;
    stNext  = stReg;
    // Synchroniser chain for the reference pin
    stNext.refSync = {stReg.refSync[1:0], pdmRefClk};
    // Register writes
    if (wrStb) begin
      if (addr == ipc_pkg::ADDR_RATE_CFG) begin
        stNext.rateMode = wdata[ipc_pkg::RATE_MODE_BIT];
      end
      for (int p = 0; p < 2; p++) begin
        if (addr == (p == 0 ? ipc_pkg::ADDR_P1_CFG : ipc_pkg::ADDR_P2_CFG)) begin
          stNext.osr[p]     = wdata[ipc_pkg::OSR_LSB +: 3];
          stNext.keepBit[p] = wdata[ipc_pkg::KEEP_BIT];
          stNext.digital[p] = wdata[ipc_pkg::DIGITAL_BIT];
        end
      end
      for (int c = 0; c < 4; c++) begin
        if (addr == srcAddr(c)) begin
          code = wdata[ipc_pkg::SRC_LSB +: 2];
          // Reserved source codes leave the field as it was
          if (code == ipc_pkg::SRC_DIFF || code == ipc_pkg::SRC_SINGLE ||
              (c == 0 && code == ipc_pkg::SRC_DIFF_ALT)) begin
            stNext.src[c] = code;
          end
          stNext.hpf[c]      = wdata[ipc_pkg::HPF_EN_BIT];
          stNext.lowPower[c] = wdata[ipc_pkg::LOW_POWER_BIT];
        end
        if (addr == gainAddr(c)) begin
          g = wdata[ipc_pkg::GAIN_LSB +: 7];
          // Reserved gain codes are ignored
          if (g >= ipc_pkg::GAIN_RESET && g <= ipc_pkg::GAIN_MAX) begin
            stNext.gain[c] = g;
          end
        end
      end
      if (addr == ipc_pkg::ADDR_HPF_CUT &&
          wdata[2:0] <= ipc_pkg::HPF_CUT_MAX) begin
        stNext.hpfCut = wdata[2:0];
      end
      if (addr == ipc_pkg::ADDR_TRIGGER) begin
        newTrig     = wdata[ipc_pkg::TRIGGER_BIT];
        stNext.trig = newTrig;
      end
    end
    // Level change on the trigger moves analog paths only
    if (newTrig != stReg.trig) begin
      for (int p = 0; p < 2; p++) begin
        if (!stReg.digital[p]) begin
          stNext.stdMode[p] = newTrig;
        end
      end
    end
    // Channel controls toward the front end
    for (int c = 0; c < 4; c++) begin
      stNext.chanOut[c].digital        = stReg.digital[c / 2];
      stNext.chanOut[c].sourceSel      = stReg.src[c];
      stNext.chanOut[c].highpassEnable = stReg.hpf[c];
      stNext.chanOut[c].effectiveGain  = stReg.gain[c];
      if (stReg.digital[c / 2]) begin
        stNext.chanOut[c].powerMode = (stReg.osr[c / 2] == ipc_pkg::OSR_PDM_6M144) ?
                                      ipc_pkg::PWR_PDM_HIGH_PERF :
                                      ipc_pkg::PWR_PDM;
      end else if (stReg.lowPower[c]) begin
        stNext.chanOut[c].powerMode = ipc_pkg::PWR_LOW_POWER;
      end else if (stReg.osr[c / 2] == ipc_pkg::OSR_MID_POWER) begin
        stNext.chanOut[c].powerMode = ipc_pkg::PWR_MID_POWER;
        if (stReg.gain[c] < ipc_pkg::GAIN_MID_MIN) begin
          stNext.chanOut[c].effectiveGain = ipc_pkg::GAIN_MID_MIN;
        end
      end else if (stReg.stdMode[c / 2]) begin
        stNext.chanOut[c].powerMode = ipc_pkg::PWR_STANDARD;
      end else begin
        stNext.chanOut[c].powerMode = ipc_pkg::PWR_HIGH_PERF;
      end
    end
    // Sample rate limits, shared limit is the tighter of the two
    for (int p = 0; p < 2; p++) begin
      stNext.maxRate[p] = rateLimit(stReg.digital[p], stReg.osr[p]);
    end
    stNext.sharedRate = (stReg.maxRate[0] < stReg.maxRate[1]) ?
                        stReg.maxRate[0] : stReg.maxRate[1];
    // Read data, unmapped addresses read zero
    if (rdStb) begin
      stNext.rdata = 32'h0000_0000;
      if (addr == ipc_pkg::ADDR_RATE_CFG) begin
        stNext.rdata[ipc_pkg::RATE_MODE_BIT] = stReg.rateMode;
      end
      for (int p = 0; p < 2; p++) begin
        if (addr == (p == 0 ? ipc_pkg::ADDR_P1_CFG : ipc_pkg::ADDR_P2_CFG)) begin
          stNext.rdata[ipc_pkg::OSR_LSB +: 3]  = stReg.osr[p];
          stNext.rdata[ipc_pkg::KEEP_BIT]      = stReg.keepBit[p];
          stNext.rdata[ipc_pkg::DIGITAL_BIT]   = stReg.digital[p];
        end
      end
      for (int c = 0; c < 4; c++) begin
        if (addr == srcAddr(c)) begin
          stNext.rdata[ipc_pkg::SRC_LSB +: 2]   = stReg.src[c];
          stNext.rdata[ipc_pkg::HPF_EN_BIT]     = stReg.hpf[c];
          stNext.rdata[ipc_pkg::LOW_POWER_BIT]  = stReg.lowPower[c];
        end
        if (addr == gainAddr(c)) begin
          stNext.rdata[ipc_pkg::GAIN_LSB +: 7]  = stReg.gain[c];
        end
      end
      if (addr == ipc_pkg::ADDR_HPF_CUT) begin
        stNext.rdata[2:0] = stReg.hpfCut;
      end
      if (addr == ipc_pkg::ADDR_TRIGGER) begin
        stNext.rdata[ipc_pkg::TRIGGER_BIT] = stReg.trig;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stReg <= resetState();
    end else begin
      stReg <= stNext;
    end
  end

  // One PDM clock generator per path
  ipc_pdm_divider uDivP1 (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .refTick        (refTick),
    .enable         (stReg.digital[0]),
    .oversampleCode (stReg.osr[0]),
    .pdmClockOut    (pdm_clock_out[0])
  );

  ipc_pdm_divider uDivP2 (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .refTick        (refTick),
    .enable         (stReg.digital[1]),
    .oversampleCode (stReg.osr[1]),
    .pdmClockOut    (pdm_clock_out[1])
  );

  // Outputs
  assign rdata                  = stReg.rdata;
  assign chanCtl                = stReg.chanOut;
  assign highpass_cutoff_select = stReg.hpfCut;
  assign rateMode               = stReg.rateMode;
  assign pathMaxRate            = stReg.maxRate;
  assign sharedMaxRate          = stReg.sharedRate;

  // Checks
  default clocking cbMain @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence sTrigRise;
    wrStb && addr == ipc_pkg::ADDR_TRIGGER && wdata[0] && !stReg.trig;
  endsequence

  sequence sTrigFall;
    wrStb && addr == ipc_pkg::ADDR_TRIGGER && !wdata[0] && stReg.trig;
  endsequence

  AST_RESET_VALUES: assert property (!$past(rst_n) |-> stReg.rateMode &&
      stReg.stdMode == 2'h0 && stReg.osr[0] == ipc_pkg::OSR_RESET &&
      stReg.gain[0] == ipc_pkg::GAIN_RESET)
    else $error("Reset values wrong");
  AST_MODE_WRITE: assert property (wrStb && addr == ipc_pkg::ADDR_P1_CFG |=>
      stReg.digital[0] == $past(wdata[0]) && stReg.osr[0] == $past(wdata[18:16]))
    else $error("Path mode write lost");
  AST_SRC_ALT: assert property (stReg.src[1] != ipc_pkg::SRC_DIFF_ALT &&
      stReg.src[2][1] == 1'b0 && stReg.src[3][1] == 1'b0)
    else $error("Reserved source held");
  AST_GAIN_RESERVED: assert property (wrStb && addr == ipc_pkg::ADDR_P1L_GAIN &&
      wdata[7:1] < ipc_pkg::GAIN_RESET |=> $stable(stReg.gain[0]))
    else $error("Reserved gain taken");
  AST_HPF_CUT: assert property (stReg.hpfCut <= ipc_pkg::HPF_CUT_MAX)
    else $error("Cut-off reserved");
  AST_TRIG_RISE: assert property (sTrigRise ##0 !stReg.digital[0] |=>
      stReg.stdMode[0] ##2 chanCtl[0].powerMode == ipc_pkg::PWR_STANDARD ||
      chanCtl[0].powerMode != ipc_pkg::PWR_HIGH_PERF)
    else $error("Standard mode not entered");
  AST_TRIG_FALL: assert property (sTrigFall ##0 !stReg.digital[0] |=>
      !stReg.stdMode[0])
    else $error("High-performance not restored");
  AST_DIGITAL_KEEP: assert property ((sTrigRise or sTrigFall) ##0 stReg.digital[1] |=>
      stReg.stdMode[1] == $past(stReg.stdMode[1]))
    else $error("Digital path mode changed");
  AST_MID_GAIN: assert property (chanCtl[1].powerMode == ipc_pkg::PWR_MID_POWER |->
      chanCtl[1].effectiveGain >= ipc_pkg::GAIN_MID_MIN)
    else $error("Mid-power gain below 6 dB");
  AST_PDM_HP: assert property (stReg.digital[0] &&
      stReg.osr[0] == ipc_pkg::OSR_PDM_6M144 && $stable(stReg.osr[0]) |=>
      chanCtl[0].powerMode == ipc_pkg::PWR_PDM_HIGH_PERF)
    else $error("PDM high-performance missing");
  AST_SHARED_LIMIT: assert property (stReg.digital[0] &&
      stReg.osr[0] == 3'h0 && $stable(stReg.osr[0]) && $stable(stReg.digital[0]) |=>
      ##1 sharedMaxRate == ipc_pkg::RATE_MAX_48K)
    else $error("Shared rate limit missing");

  // Per-path limits trail the path configuration by one cycle, the shared limit by two
  AST_LIMIT_96K: assert property (stReg.digital[0] && stReg.osr[0] == 3'h1 |=>
      pathMaxRate[0] == ipc_pkg::RATE_MAX_96K)
    else $error("96 kHz limit missing");
  // An analog path never sends a clock toward the mics
  AST_ANALOG_CLK_LOW: assert property (!stReg.digital[0] |=> !pdm_clock_out[0])
    else $error("PDM clock runs on analog path");
  // Channel digital flag follows its path mode bit
  AST_CHAN_DIGITAL: assert property (chanCtl[3].digital == $past(stReg.digital[1]))
    else $error("Channel digital flag wrong");

endmodule : ipc_input_path_config

// ==== rtl/ipc_pdm_divider.sv ====
// Purpose: Generates one PDM clock from reference ticks and an oversample code
// Assumes: refTick is a one-cycle pulse per rising reference edge, on mclk
// Notes:   Reserved code or analog path holds the clock low
`timescale 1ns/100ps
module ipc_pdm_divider (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       refTick,
  input  wire logic       enable,
  input  wire logic [2:0] oversampleCode,
  output logic            pdmClockOut
);

  // Divider state
  typedef struct packed {
    logic [5:0] count;
    logic       clk;
  } ipc_div_type;

  ipc_div_type divReg;  // Registered state
  ipc_div_type divNext; // Next state
  logic [5:0]  halfLen; // Ticks per half period

  // Half period lookup per oversample code
  always_comb begin
    unique case (oversampleCode)
      3'h0:    halfLen = ipc_pkg::HALF_384K;
      3'h1:    halfLen = ipc_pkg::HALF_768K;
      3'h2:    halfLen = ipc_pkg::HALF_1M536;
      3'h3:    halfLen = ipc_pkg::HALF_2M048;
      3'h4:    halfLen = ipc_pkg::HALF_2M4576;
      3'h5:    halfLen = ipc_pkg::HALF_3M072;
      3'h6:    halfLen = ipc_pkg::HALF_6M144;
      default: halfLen = 6'h00;
    endcase
  end

  // Count ticks and toggle at each half period
  always_comb begin
    divNext = divReg;
    if (!enable || oversampleCode == ipc_pkg::OSR_RESERVED) begin
      divNext = '0;
    end else if (refTick) begin
      if (divReg.count + 6'h01 >= halfLen) begin
        divNext.count = 6'h00;
        divNext.clk   = ~divReg.clk;
      end else begin
        divNext.count = divReg.count + 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      divReg <= '0;
    end else begin
      divReg <= divNext;
    end
  end

  assign pdmClockOut = divReg.clk;

endmodule : ipc_pdm_divider

// ==== shared/ipc_pkg.sv ====
// Purpose: Shared constants and types of the input path configuration block
// Assumes: Register port with a 20-bit byte address and 32-bit data
// Notes:   Channel index 0 = path 1 left, 1 = path 1 right, 2 = path 2 left, 3 = path 2 right
package ipc_pkg;

  // Register byte addresses
  localparam logic [19:0] ADDR_RATE_CFG   = 20'h04008;
  localparam logic [19:0] ADDR_P1_CFG     = 20'h04020;
  localparam logic [19:0] ADDR_P1L_SRC    = 20'h04024;
  localparam logic [19:0] ADDR_P1L_GAIN   = 20'h04028;
  localparam logic [19:0] ADDR_P1R_SRC    = 20'h04044;
  localparam logic [19:0] ADDR_P1R_GAIN   = 20'h04048;
  localparam logic [19:0] ADDR_P2_CFG     = 20'h04060;
  localparam logic [19:0] ADDR_P2L_SRC    = 20'h04064;
  localparam logic [19:0] ADDR_P2L_GAIN   = 20'h04068;
  localparam logic [19:0] ADDR_P2R_SRC    = 20'h04084;
  localparam logic [19:0] ADDR_P2R_GAIN   = 20'h04088;
  localparam logic [19:0] ADDR_HPF_CUT    = 20'h04244;
  localparam logic [19:0] ADDR_TRIGGER    = 20'h19000;

  // Field positions
  localparam int RATE_MODE_BIT  = 10;
  localparam int OSR_LSB        = 16;
  localparam int KEEP_BIT       = 5;
  localparam int DIGITAL_BIT    = 0;
  localparam int SRC_LSB        = 28;
  localparam int HPF_EN_BIT     = 2;
  localparam int LOW_POWER_BIT  = 0;
  localparam int GAIN_LSB       = 1;
  localparam int TRIGGER_BIT    = 0;

  // Reset values and codes
  localparam logic       RATE_MODE_RESET = 1'h1;
  localparam logic [2:0] OSR_RESET       = 3'h5;
  localparam logic [2:0] OSR_MID_POWER   = 3'h2;
  localparam logic [2:0] OSR_PDM_6M144   = 3'h6;
  localparam logic [2:0] OSR_RESERVED    = 3'h7;
  localparam logic [1:0] SRC_DIFF        = 2'h0;
  localparam logic [1:0] SRC_SINGLE      = 2'h1;
  localparam logic [1:0] SRC_DIFF_ALT    = 2'h2;
  localparam logic [6:0] GAIN_RESET      = 7'h40;
  localparam logic [6:0] GAIN_MAX        = 7'h5d;
  localparam logic [6:0] GAIN_MID_MIN    = 7'h46;
  localparam logic [2:0] HPF_CUT_RESET   = 3'h2;
  localparam logic [2:0] HPF_CUT_MAX     = 3'h4;

  // Highest allowed sample rate codes
  localparam logic [1:0] RATE_MAX_48K    = 2'h0;
  localparam logic [1:0] RATE_MAX_96K    = 2'h1;
  localparam logic [1:0] RATE_MAX_192K   = 2'h2;

  // Reference tick half periods per code, nominal 24.576 MHz reference
  localparam logic [5:0] HALF_384K   = 6'h20;
  localparam logic [5:0] HALF_768K   = 6'h10;
  localparam logic [5:0] HALF_1M536  = 6'h08;
  localparam logic [5:0] HALF_2M048  = 6'h06;
  localparam logic [5:0] HALF_2M4576 = 6'h05;
  localparam logic [5:0] HALF_3M072  = 6'h04;
  localparam logic [5:0] HALF_6M144  = 6'h02;

  // Operating mode of one channel
  typedef enum logic [2:0] {
    PWR_HIGH_PERF,
    PWR_STANDARD,
    PWR_LOW_POWER,
    PWR_MID_POWER,
    PWR_PDM,
    PWR_PDM_HIGH_PERF
  } ipc_power_type;

  // Control bundle driven toward one channel of the front end
  typedef struct packed {
    ipc_power_type powerMode;
    logic          digital;
    logic [1:0]    sourceSel;
    logic          highpassEnable;
    logic [6:0]    effectiveGain;
  } ipc_chan_type;

endpackage : ipc_pkg
